//--- design/lsrc_pkg.sv
// package: register map, field layout and reset values of the low-supply reset control
package lsrc_pkg;

    // =========================================================
    // register byte offsets
    localparam logic [7:0] LSRC_CFG_OFS = 8'h00;
    localparam logic [7:0] LSRC_STATUS_OFS = 8'h04;
    localparam logic [7:0] LSRC_EVT_STAT_OFS = 8'h08;
    localparam logic [7:0] LSRC_EVT_MASK_OFS = 8'h0C;

    // =========================================================
    // configuration_register_one fields
    localparam int LSRC_CFG_PWRD_BIT = 0;
    localparam int LSRC_CFG_RSTD_BIT = 1;
    localparam int LSRC_CFG_STOPEN_BIT = 2;
    localparam int LSRC_CFG_W = 3;
    // monitor enabled, resets enabled, off in stop
    localparam logic [2:0] LSRC_CFG_RST = 3'h0;

    // =========================================================
    // supply_status_register fields
    localparam int LSRC_STAT_FLAG_BIT = 0;
    localparam int LSRC_STAT_HOLD_BIT = 1;
    localparam int LSRC_STAT_ACTIVE_BIT = 2;

    // =========================================================
    // event status / mask fields
    localparam int LSRC_EVT_FLAG_SET_BIT = 0;
    localparam int LSRC_EVT_FLAG_CLR_BIT = 1;
    localparam int LSRC_EVT_RESET_BIT = 2;
    localparam int LSRC_EVT_W = 3;
    localparam logic [2:0] LSRC_EVT_RST = 3'h0;

    localparam int LSRC_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        LSRC_BUS_IDLE = 2'b00,
        LSRC_BUS_WAIT = 2'b01,
        LSRC_BUS_DONE = 2'b10
    } lsrc_bus_state_t;

endpackage : lsrc_pkg

//--- design/lsrc_sync2.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module lsrc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : lsrc_sync2

//--- design/lsrc_ahb_slave.sv
// ahb-lite slave front end: one wait state per transfer, turns transfers into strobes
`timescale 1ns/1ps
module lsrc_ahb_slave
    import lsrc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] acc_addr
);
    lsrc_bus_state_t state_r;
    logic write_r;
    logic take;

    // htrans[1] covers NONSEQ and SEQ; only whole words are used, hsize is not checked
    assign take = hsel && hready && htrans[1];
    assign hreadyout = (state_r != LSRC_BUS_WAIT);
    assign hresp = 1'b0;
    assign wr_stb = (state_r == LSRC_BUS_WAIT) && write_r;
    assign rd_stb = (state_r == LSRC_BUS_WAIT) && !write_r;

    // =========================================================
    // transfer sequencing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= LSRC_BUS_IDLE;
            write_r <= 1'b0;
            acc_addr <= 8'h00;
        end else begin
            unique case (state_r)
                LSRC_BUS_IDLE, LSRC_BUS_DONE: begin
                    if (take) begin
                        state_r <= LSRC_BUS_WAIT;
                        write_r <= hwrite;
                        acc_addr <= {haddr[7:2], 2'b00};
                    end else begin
                        state_r <= LSRC_BUS_IDLE;
                    end
                end
                LSRC_BUS_WAIT: begin
                    state_r <= LSRC_BUS_DONE;
                end
                default: begin
                    state_r <= LSRC_BUS_IDLE;
                end
            endcase
        end
    end
endmodule : lsrc_ahb_slave

//--- design/lsrc_top.sv
// low-supply reset control: monitor gating, hysteretic flag, reset hold and register file
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module lsrc_top
    import lsrc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic below_falling_trip,
    input wire logic above_rising_trip,
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic monitor_power_down,
    output logic supply_reset_req,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic wake_req,
    output logic event_irq
);
    // =========================================================
    // register decode, shared by the config and mask writes and the event-status read; the read-data mux decodes acc_addr itself
    function automatic logic reg_hit(input logic stb, input logic [7:0] addr,
        input logic [7:0] ofs);
        return stb && (addr == ofs);
    endfunction : reg_hit

    // =========================================================
    // bus front end
    logic wr_stb;
    logic rd_stb;
    logic [7:0] acc_addr;

    lsrc_ahb_slave u_bus (
        .clk(clk),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .acc_addr(acc_addr)
    );

    // =========================================================
    // comparator inputs
    logic [1:0] cmp_sync;
    logic below_fall_s;
    logic above_rise_s;

    lsrc_sync2 #(.WIDTH(2)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({below_falling_trip, above_rising_trip}),
        .sync_out(cmp_sync)
    );
    assign below_fall_s = cmp_sync[1];
    assign above_rise_s = cmp_sync[0];

    // =========================================================
    // configuration_register_one
    logic [LSRC_CFG_W-1:0] cfg_r;
    logic supply_reset_disable;
    logic stop_mode_monitor_enable;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= LSRC_CFG_RST;
        end else if (reg_hit(wr_stb, acc_addr, LSRC_CFG_OFS)) begin
            cfg_r <= hwdata[LSRC_CFG_W-1:0];
        end
    end
    assign monitor_power_down = cfg_r[LSRC_CFG_PWRD_BIT];
    assign supply_reset_disable = cfg_r[LSRC_CFG_RSTD_BIT];
    assign stop_mode_monitor_enable = cfg_r[LSRC_CFG_STOPEN_BIT];

    // =========================================================
    // monitor gating
    logic monitor_active;
    logic reset_allowed;

    // wait mode never gates the monitor; stop mode needs its own enable
    assign monitor_active = !monitor_power_down
        && (!stop_mode || stop_mode_monitor_enable);
    assign reset_allowed = monitor_active && !supply_reset_disable;

    // =========================================================
    // hysteretic low-supply flag
    logic low_supply_flag;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_supply_flag <= 1'b0;
        end else if (!monitor_active) begin
            low_supply_flag <= low_supply_flag;
        end else if (below_fall_s) begin
            low_supply_flag <= 1'b1;
        end else if (above_rise_s) begin
            low_supply_flag <= 1'b0;
        end
    end

    // =========================================================
    // reset hold
    logic reset_hold_r;
    logic reset_fire;

    assign reset_fire = reset_allowed && below_fall_s && !reset_hold_r;
    // once fired, only the rising level releases it; the config cannot cut it short
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_hold_r <= 1'b0;
        end else if (reset_fire) begin
            reset_hold_r <= 1'b1;
        end else if (reset_hold_r && above_rise_s && !below_fall_s) begin
            reset_hold_r <= 1'b0;
        end
    end

    // open-drain reset pin: only ever pulled low
    assign supply_reset_req = reset_hold_r;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = reset_hold_r;
    assign wake_req = reset_hold_r && (wait_mode || stop_mode);

    // =========================================================
    // event status, read-to-clear, and mask
    logic [LSRC_EVT_W-1:0] evt_stat_r;
    logic [LSRC_EVT_W-1:0] evt_mask_r;
    logic [LSRC_EVT_W-1:0] evt_set;
    logic flag_d_r;
    logic evt_rd;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_d_r <= 1'b0;
        end else begin
            flag_d_r <= low_supply_flag;
        end
    end

    always_comb begin
        evt_set = '0;
        evt_set[LSRC_EVT_FLAG_SET_BIT] = low_supply_flag && !flag_d_r;
        evt_set[LSRC_EVT_FLAG_CLR_BIT] = !low_supply_flag && flag_d_r;
        evt_set[LSRC_EVT_RESET_BIT] = reset_fire;
    end

    assign evt_rd = reg_hit(rd_stb, acc_addr, LSRC_EVT_STAT_OFS);
    // a new event in the reading cycle survives the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_stat_r <= LSRC_EVT_RST;
        end else if (evt_rd) begin
            evt_stat_r <= evt_set;
        end else begin
            evt_stat_r <= evt_stat_r | evt_set;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_mask_r <= LSRC_EVT_RST;
        end else if (reg_hit(wr_stb, acc_addr, LSRC_EVT_MASK_OFS)) begin
            evt_mask_r <= hwdata[LSRC_EVT_W-1:0];
        end
    end

    // system-side line, masked off after reset; the monitor makes no cpu request of its own
    assign event_irq = |(evt_stat_r & evt_mask_r);

    // =========================================================
    // read data; writes to the status registers are ignored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            unique case (acc_addr)
                LSRC_CFG_OFS: hrdata <= {29'h0000_0000, cfg_r};
                LSRC_STATUS_OFS: hrdata <= {29'h0000_0000, monitor_active,
                    reset_hold_r, low_supply_flag};
                LSRC_EVT_STAT_OFS: hrdata <= {29'h0000_0000, evt_stat_r};
                LSRC_EVT_MASK_OFS: hrdata <= {29'h0000_0000, evt_mask_r};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : lsrc_top

//--- sim/lsrc_supply_model.sv
// comparator pair model: turns a supply band code into asynchronous trip levels
`timescale 1ns/1ps
module lsrc_supply_model (
    input wire logic [1:0] level,
    output logic below_falling_trip,
    output logic above_rising_trip
);
    // =====================================
    // 0 above rising, 1 between, 2 below falling; edges land off the clock
    initial {below_falling_trip, above_rising_trip} = 2'b01;
    always @(level) begin
        #3 below_falling_trip = (level == 2'd2);
        above_rising_trip = (level == 2'd0);
    end
endmodule : lsrc_supply_model

//--- sim/lsrc_top_props.sv
// checker for the low-supply reset control ports
`timescale 1ns/1ps
module lsrc_top_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic below_falling_trip,
    input wire logic above_rising_trip,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic monitor_power_down,
    input wire logic supply_reset_req,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic wake_req
);
    // =====================================
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    oe_tracks_req_a: assert property (reset_pin_oe == supply_reset_req)
        else $error("pin enable differs from reset request");
    pin_low_a: assert property (reset_pin_oe |-> !reset_pin_out)
        else $error("reset pin not driven low");
    fire_cause_a: assert property ($rose(supply_reset_req) |-> $past(below_falling_trip, 3))
        else $error("reset fired without synchronised low supply");
    power_down_quiet_a: assert property ($rose(supply_reset_req) |-> !$past(monitor_power_down))
        else $error("reset fired while powered down");
    release_cause_a: assert property ($fell(supply_reset_req) |->
        $past(above_rising_trip, 3) && !$past(below_falling_trip, 3))
        else $error("reset released below rising level");
    hold_between_a: assert property (!above_rising_trip [*3] ##1 supply_reset_req
        |=> supply_reset_req)
        else $error("reset dropped without rising level");
    wake_form_a: assert property (wake_req == (supply_reset_req && (wait_mode || stop_mode)))
        else $error("wake request mismatch");
    bus_wait_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
        else $error("bus wait state wrong");
    okay_resp_a: assert property (!hresp)
        else $error("bus response not okay");
endmodule : lsrc_top_props

bind lsrc_top lsrc_top_props lsrc_top_props_inst (.clk, .resetn, .hsel, .hready, .htrans,
    .hreadyout, .hresp, .below_falling_trip, .above_rising_trip, .wait_mode, .stop_mode,
    .monitor_power_down, .supply_reset_req, .reset_pin_out, .reset_pin_oe, .wake_req);

//--- sim/lsrc_top_tb.sv
// self-checking bench for the low-supply reset control
`timescale 1ns/1ps
module lsrc_top_tb;
    import lsrc_pkg::*;
    logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, wait_mode = 0, stop_mode = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, level = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, below_falling_trip, above_rising_trip, monitor_power_down;
    logic supply_reset_req, reset_pin_out, reset_pin_oe, wake_req, event_irq;
    int n_fail = 0, tests_run = 0;

    always #4 clk = ~clk;
    lsrc_supply_model lsrc_supply_model_inst (.level, .below_falling_trip, .above_rising_trip);
    lsrc_top lsrc_top_inst (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .below_falling_trip,
        .above_rising_trip, .wait_mode, .stop_mode, .monitor_power_down, .supply_reset_req,
        .reset_pin_out, .reset_pin_oe, .wake_req, .event_irq);

    // =====================================
    // helpers
    task report_and_stop;
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk
    // hreadyout is sampled at the falling edge, where it equals its value at the next rise
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        logic r;
        n = 0;
        @(posedge clk);
        hsel <= 1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do begin @(negedge clk); r = hreadyout; @(posedge clk); n++; end while (r !== 1 && n < 20);
        if (r !== 1) begin n_fail++; report_and_stop(); end
        hsel <= 0;
        htrans <= 0;
        hwdata <= wd;
        do begin
            @(negedge clk); r = hreadyout; rd = hrdata; @(posedge clk); n++;
        end while (r !== 1 && n < 40);
        if (r !== 1) begin n_fail++; report_and_stop(); end
    endtask : xfer
    task settle(input int c);
        repeat (c) @(negedge clk);
    endtask : settle
    task wait_req(input logic v);
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (supply_reset_req !== v && n < 20);
        if (supply_reset_req !== v) begin n_fail++; report_and_stop(); end
    endtask : wait_req

    // =====================================
    // scenarios
    task t_reset;
        xfer(0, LSRC_CFG_OFS, 0); chk("cfg", rd, 32'h0000_0000);
        xfer(0, LSRC_STATUS_OFS, 0); chk("status", rd, 32'h0000_0004);
        xfer(0, 8'h10, 0); chk("unmapped", rd, 32'h0000_0000);
    endtask : t_reset
    task t_forced;
        level <= 2; wait_req(1);
        chk("oe", reset_pin_oe, 1);
        chk("pin", reset_pin_out, 0);
        chk("irq", event_irq, 0);
        xfer(0, LSRC_STATUS_OFS, 0); chk("flag low", rd, 32'h0000_0007);
        level <= 1; settle(8);
        chk("hold", supply_reset_req, 1);
        xfer(0, LSRC_STATUS_OFS, 0); chk("flag held", rd, 32'h0000_0007);
        level <= 0; wait_req(0);
        xfer(1, LSRC_STATUS_OFS, 32'hFFFF_FFFF);
        xfer(0, LSRC_STATUS_OFS, 0); chk("flag ro", rd, 32'h0000_0004);
        xfer(0, LSRC_EVT_STAT_OFS, 0); chk("evt", rd, 32'h0000_0007);
        xfer(0, LSRC_EVT_STAT_OFS, 0); chk("evt clr", rd, 32'h0000_0000);
    endtask : t_forced
    task t_wake;
        xfer(1, LSRC_EVT_MASK_OFS, 32'h0000_0004);
        wait_mode <= 1; level <= 2; wait_req(1);
        chk("wake", wake_req, 1);
        chk("irq on", event_irq, 1);
        xfer(0, LSRC_EVT_STAT_OFS, 0); chk("evt", rd, 32'h0000_0005);
        settle(1); chk("irq off", event_irq, 0);
        level <= 0; wait_req(0);
        @(posedge clk); wait_mode <= 0;
    endtask : t_wake
    task t_polled;
        xfer(1, LSRC_CFG_OFS, 32'h0000_0002);
        level <= 1; settle(8);
        xfer(0, LSRC_STATUS_OFS, 0); chk("between", rd, 32'h0000_0004);
        level <= 2; settle(8);
        chk("no reset", supply_reset_req, 0);
        xfer(0, LSRC_STATUS_OFS, 0); chk("polled", rd, 32'h0000_0005);
        level <= 0; settle(8);
        xfer(0, LSRC_STATUS_OFS, 0); chk("follow", rd, 32'h0000_0004);
    endtask : t_polled
    task t_pwrdn;
        xfer(1, LSRC_CFG_OFS, 32'h0000_0001);
        level <= 2; settle(8);
        chk("pd out", monitor_power_down, 1);
        chk("pd reset", supply_reset_req, 0);
        xfer(0, LSRC_STATUS_OFS, 0); chk("pd flag", rd[0], 0);
        level <= 0;
        xfer(1, LSRC_CFG_OFS, 0);
    endtask : t_pwrdn
    task t_stop;
        @(posedge clk); stop_mode <= 1;
        level <= 2; settle(8);
        chk("stop off", supply_reset_req, 0);
        xfer(1, LSRC_CFG_OFS, 32'h0000_0006); settle(8);
        chk("stop no rst", supply_reset_req, 0);
        xfer(0, LSRC_STATUS_OFS, 0); chk("stop flag", rd, 32'h0000_0005);
        xfer(1, LSRC_CFG_OFS, 32'h0000_0004); wait_req(1);
        chk("stop wake", wake_req, 1);
        level <= 0; wait_req(0);
        @(posedge clk); stop_mode <= 0;
    endtask : t_stop

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1;
        t_reset(); t_forced(); t_wake(); t_polled(); t_pwrdn(); t_stop();
        report_and_stop();
    end
endmodule : lsrc_top_tb
